// File: pkg/rtc_pkg.sv
// Package for the calendar real-time clock core: map, fields, reset values, bus carriers
package rtc_pkg;
  // Clock rate and prescaler division down to the 64 Hz tick
  localparam int unsigned CLK_HZ    = 100_000_000;
  localparam int unsigned TICK_HZ   = 64;
  localparam int unsigned PRESC_DIV = CLK_HZ / TICK_HZ;

  // Register byte offsets; time and alarm fields are word arrays from a base
  localparam logic [7:0] OFF_CNT64  = 8'h00;
  localparam logic [7:0] OFF_TIME   = 8'h04;
  localparam logic [7:0] OFF_ALARM  = 8'h20;
  localparam logic [7:0] OFF_CTRL1  = 8'h38;
  localparam logic [7:0] OFF_CTRL2  = 8'h3C;

  // Field counts: time is sec, min, hour, weekday, date, month, year
  localparam int NUM_TIME  = 7;
  localparam int NUM_ALARM = 6;
  localparam int IDX_SEC   = 0;
  localparam int IDX_MIN   = 1;
  localparam int IDX_HOUR  = 2;
  localparam int IDX_WDAY  = 3;
  localparam int IDX_DATE  = 4;
  localparam int IDX_MON   = 5;
  localparam int IDX_YEAR  = 6;

  // Limits and first values of each field (date limit is replaced per month)
  localparam logic [7:0] TIME_MAX   [NUM_TIME] = '{8'h3B, 8'h3B, 8'h17, 8'h06, 8'h1F, 8'h0C, 8'h63};
  localparam logic [7:0] TIME_FIRST [NUM_TIME] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
  localparam logic [5:0] CNT64_MAX  = 6'h3F;

  // Control register one bits
  localparam int CTL1_ALARM_FLAG = 0;
  localparam int CTL1_ALARM_IE   = 3;
  // Control register two bits
  localparam int CTL2_RUN        = 0;
  localparam int CTL2_DIV_RESET  = 1;
  localparam int CTL2_OSC_EN     = 3;
  localparam int CTL2_PER_SEL_LO = 4;
  localparam int CTL2_PER_FLAG   = 7;
  localparam int ALARM_EN_BIT    = 7;

  // Reset values of control bits
  localparam logic       RST_RUN     = 1'b1;
  localparam logic       RST_OSC_EN  = 1'b1;
  localparam logic [2:0] RST_PER_SEL = 3'h0;

  // Periodic select: mask of 64 Hz count bits that must roll to zero (1/64 s .. 1 s)
  localparam logic [5:0] PER_MASK [8] = '{6'h00, 6'h00, 6'h01, 6'h03, 6'h07, 6'h0F, 6'h1F, 6'h3F};

  // APB request and response carriers
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } rtc_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } rtc_apb_rsp_t;
endpackage

// File: logic/rtc_core.sv
// Calendar real-time clock core with alarm, periodic event and APB register slave
//
// Functional notes
// - Writing one to divider reset clears prescaler and 64 Hz count; reads zero
// - Run bit, reset to one, advances second..year counters; zero freezes them
// - The 64 Hz counter ignores run; only oscillator enable stops it
// - Alarm compares any combination of second, minute, hour, weekday, date, month
// - Alarm register bit 7 enables the field; lower bits hold the value
// - Match of all enabled fields sets alarm flag, control one bit 0
// - Alarm interrupt enable, control one bit 3, raises alarm interrupt request
// - Time counters ignore writes while run bit is one
// - Each elapsed periodic interval, chosen by three-bit select, sets periodic flag
// - Periodic flag clears as the periodic interrupt pulse is generated
`timescale 1ns/1ps
module rtc_core #(
  parameter int unsigned PRESC_DIV_P = rtc_pkg::PRESC_DIV
) (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  // APB slave
  input  wire rtc_pkg::rtc_apb_req_t apb_req,
  output rtc_pkg::rtc_apb_rsp_t      apb_rsp,
  // Event requests
  output logic                 alarm_irq,
  output logic                 periodic_irq
);
  import rtc_pkg::*;

  localparam int PW = $clog2(PRESC_DIV_P);

  // Days in the current month, leap year on year divisible by four
  function automatic logic [7:0] days_in(input logic [7:0] mon, input logic [7:0] yr);
    logic [7:0] d;
    d = 8'h1F;
    if (mon == 8'h02) begin
      d = (yr[1:0] == 2'h0) ? 8'h1D : 8'h1C;
    end else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h0B) begin
      d = 8'h1E;
    end
    return d;
  endfunction

  // A field passes when its enable is clear or its value equals the time
  function automatic logic field_ok(input logic [7:0] alm, input logic [7:0] cur);
    return !alm[ALARM_EN_BIT] || (alm[6:0] == cur[6:0]);
  endfunction

  // State
  logic [PW-1:0] pre_ff;
  logic [5:0]    cnt64_ff;
  logic [7:0]    tm_ff     [NUM_TIME];
  logic [7:0]    nxt_tm    [NUM_TIME];
  logic [7:0]    alarm_ff  [NUM_ALARM];
  logic          run_ff;
  logic          osc_en_ff;
  logic [2:0]    per_sel_ff;
  logic          per_flag_ff;
  logic          alarm_flag_ff;
  logic          alarm_ie_ff;
  logic          tick_d_ff;
  rtc_apb_rsp_t  rsp_ff;
  logic          alarm_irq_ff;
  logic          per_irq_ff;

  // Decode and event terms
  logic          acc;
  logic          wr_en;
  logic [7:0]    addr;
  logic          addr_ok;
  logic          wr_ctl1;
  logic          wr_ctl2;
  logic          div_rst;
  logic          tick64;
  logic          sec_tick;
  logic          adv;
  logic [NUM_TIME-1:0]  tm_hit;
  logic [NUM_ALARM-1:0] al_hit;
  logic [NUM_ALARM-1:0] al_ok;
  logic [NUM_ALARM-1:0] al_en;
  logic          alarm_match;
  logic          per_fire;
  logic [5:0]    cnt64_inc;
  logic [31:0]   rd_data;
  logic          rd_hit;
  logic          c_min;
  logic          c_hr;
  logic          c_day;
  logic          c_mon;
  logic          c_yr;
  logic [7:0]    dim;

  // Bus qualifiers; a write lands on the edge that also samples pready high
  assign acc     = apb_req.psel && apb_req.penable;
  assign wr_en   = acc && apb_req.pwrite && rsp_ff.pready;
  assign addr    = apb_req.paddr[7:0];
  assign addr_ok = (apb_req.paddr[31:8] == 24'h0) && (addr[1:0] == 2'h0);
  assign wr_ctl1 = wr_en && addr_ok && (addr == OFF_CTRL1);
  assign wr_ctl2 = wr_en && addr_ok && (addr == OFF_CTRL2);
  assign div_rst = wr_ctl2 && apb_req.pwdata[CTL2_DIV_RESET];

  // Address hits for the field arrays
  genvar g;
  generate
    for (g = 0; g < NUM_TIME; g++) begin : g_thit
      assign tm_hit[g] = addr_ok && (addr == OFF_TIME + 8'(4 * g));
    end
    for (g = 0; g < NUM_ALARM; g++) begin : g_ahit
      assign al_hit[g] = addr_ok && (addr == OFF_ALARM + 8'(4 * g));
      assign al_ok[g]  = field_ok(alarm_ff[g], tm_ff[g]);
      assign al_en[g]  = alarm_ff[g][ALARM_EN_BIT];
    end
  endgenerate

  // Prescaler ticks at 64 Hz while the oscillator is enabled
  assign tick64    = osc_en_ff && (pre_ff == PW'(PRESC_DIV_P - 1));
  assign sec_tick  = tick64 && (cnt64_ff == CNT64_MAX);
  assign adv       = run_ff && sec_tick;
  assign cnt64_inc = cnt64_ff + 6'h01;

  // Prescaler and 64 Hz counter; the run bit has no say here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_ff   <= '0;
      cnt64_ff <= '0;
    end else if (div_rst) begin
      pre_ff   <= '0;
      cnt64_ff <= '0;
    end else if (tick64) begin
      pre_ff   <= '0;
      cnt64_ff <= cnt64_inc;
    end else if (osc_en_ff) begin
      pre_ff   <= pre_ff + PW'(1);
    end
  end

  // Carry chain through the calendar
  always_comb begin
    dim   = days_in(tm_ff[IDX_MON], tm_ff[IDX_YEAR]);
    c_min = adv && (tm_ff[IDX_SEC] == TIME_MAX[IDX_SEC]);
    c_hr  = c_min && (tm_ff[IDX_MIN] == TIME_MAX[IDX_MIN]);
    c_day = c_hr && (tm_ff[IDX_HOUR] == TIME_MAX[IDX_HOUR]);
    c_mon = c_day && (tm_ff[IDX_DATE] == dim);
    c_yr  = c_mon && (tm_ff[IDX_MON] == TIME_MAX[IDX_MON]);
    for (int i = 0; i < NUM_TIME; i++) begin
      nxt_tm[i] = tm_ff[i];
    end
    nxt_tm[IDX_SEC]  = !adv ? tm_ff[IDX_SEC] : c_min ? TIME_FIRST[IDX_SEC]
                                                     : tm_ff[IDX_SEC] + 8'h01;
    nxt_tm[IDX_MIN]  = !c_min ? tm_ff[IDX_MIN] : c_hr ? TIME_FIRST[IDX_MIN]
                                                       : tm_ff[IDX_MIN] + 8'h01;
    nxt_tm[IDX_HOUR] = !c_hr ? tm_ff[IDX_HOUR] : c_day ? TIME_FIRST[IDX_HOUR]
                                                        : tm_ff[IDX_HOUR] + 8'h01;
    if (c_day) begin
      nxt_tm[IDX_WDAY] = (tm_ff[IDX_WDAY] >= TIME_MAX[IDX_WDAY]) ? TIME_FIRST[IDX_WDAY]
                                                                 : tm_ff[IDX_WDAY] + 8'h01;
      nxt_tm[IDX_DATE] = c_mon ? TIME_FIRST[IDX_DATE] : tm_ff[IDX_DATE] + 8'h01;
    end
    if (c_mon) begin
      nxt_tm[IDX_MON]  = c_yr ? TIME_FIRST[IDX_MON] : tm_ff[IDX_MON] + 8'h01;
    end
    if (c_yr) begin
      nxt_tm[IDX_YEAR] = (tm_ff[IDX_YEAR] >= TIME_MAX[IDX_YEAR]) ? TIME_FIRST[IDX_YEAR]
                                                                 : tm_ff[IDX_YEAR] + 8'h01;
    end
  end

  // Time and alarm registers; writing the time only works while halted
  generate
    for (g = 0; g < NUM_TIME; g++) begin : g_time
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          tm_ff[g] <= TIME_FIRST[g];
        end else if (wr_en && tm_hit[g] && !run_ff) begin
          tm_ff[g] <= apb_req.pwdata[7:0];
        end else begin
          tm_ff[g] <= nxt_tm[g];
        end
      end
    end
    for (g = 0; g < NUM_ALARM; g++) begin : g_alarm
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          alarm_ff[g] <= 8'h00;
        end else if (wr_en && al_hit[g]) begin
          alarm_ff[g] <= apb_req.pwdata[7:0];
        end
      end
    end
  endgenerate

  // Compare one cycle after the advance, when the new time has settled
  assign alarm_match = (&al_ok) && (|al_en);

  // Alarm flag: a new match beats a software clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_d_ff     <= 1'b0;
      alarm_flag_ff <= 1'b0;
      alarm_ie_ff   <= 1'b0;
      alarm_irq_ff  <= 1'b0;
    end else begin
      tick_d_ff <= adv;
      if (tick_d_ff && alarm_match) begin
        alarm_flag_ff <= 1'b1;
      end else if (wr_ctl1 && !apb_req.pwdata[CTL1_ALARM_FLAG]) begin
        alarm_flag_ff <= 1'b0;
      end
      if (wr_ctl1) begin
        alarm_ie_ff <= apb_req.pwdata[CTL1_ALARM_IE];
      end
      alarm_irq_ff <= alarm_flag_ff && alarm_ie_ff;
    end
  end

  // Periodic event on roll-over of the selected low bits of the 64 Hz count
  assign per_fire = tick64 && !div_rst && (per_sel_ff != 3'h0)
                    && ((cnt64_inc & PER_MASK[per_sel_ff]) == 6'h00);

  // Control two and periodic flag; the flag lives one cycle, then becomes the pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_ff      <= RST_RUN;
      osc_en_ff   <= RST_OSC_EN;
      per_sel_ff  <= RST_PER_SEL;
      per_flag_ff <= 1'b0;
      per_irq_ff  <= 1'b0;
    end else begin
      if (wr_ctl2) begin
        run_ff     <= apb_req.pwdata[CTL2_RUN];
        osc_en_ff  <= apb_req.pwdata[CTL2_OSC_EN];
        per_sel_ff <= apb_req.pwdata[CTL2_PER_SEL_LO +: 3];
      end
      if (per_fire) begin
        per_flag_ff <= 1'b1;
      end else if (per_flag_ff) begin // Select may just have gone to zero; never stick
        per_flag_ff <= 1'b0;
      end
      per_irq_ff <= per_flag_ff;
    end
  end

  // Read mux; divider reset bit always reads zero
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit  = addr_ok && (addr == OFF_CNT64 || addr == OFF_CTRL1 || addr == OFF_CTRL2);
    if (addr == OFF_CNT64) begin
      rd_data[5:0] = cnt64_ff;
    end
    for (int i = 0; i < NUM_TIME; i++) begin
      if (tm_hit[i]) begin
        rd_data[7:0] = tm_ff[i];
        rd_hit       = 1'b1;
      end
    end
    for (int i = 0; i < NUM_ALARM; i++) begin
      if (al_hit[i]) begin
        rd_data[7:0] = alarm_ff[i];
        rd_hit       = 1'b1;
      end
    end
    if (addr == OFF_CTRL1) begin
      rd_data[CTL1_ALARM_FLAG] = alarm_flag_ff;
      rd_data[CTL1_ALARM_IE]   = alarm_ie_ff;
    end
    if (addr == OFF_CTRL2) begin
      rd_data[CTL2_RUN]             = run_ff;
      rd_data[CTL2_DIV_RESET]       = 1'b0;
      rd_data[CTL2_OSC_EN]          = osc_en_ff;
      rd_data[CTL2_PER_SEL_LO +: 3] = per_sel_ff;
      rd_data[CTL2_PER_FLAG]        = per_flag_ff;
    end
    if (!addr_ok) begin
      rd_data = 32'h0000_0000;
    end
  end

  // APB answer: one wait state so data and ready come from flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff.pready <= acc && !rsp_ff.pready;
      if (acc && !rsp_ff.pready) begin
        rsp_ff.prdata  <= apb_req.pwrite ? 32'h0000_0000 : rd_data;
        rsp_ff.pslverr <= !rd_hit;
      end else begin
        rsp_ff.pslverr <= 1'b0;
      end
    end
  end

  assign apb_rsp      = rsp_ff;
  assign alarm_irq    = alarm_irq_ff;
  assign periodic_irq = per_irq_ff;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence per_pulse;
    per_flag_ff ##1 (periodic_irq && !per_flag_ff);
  endsequence

  AST_DIV_CLEAR: assert property (div_rst |=> (cnt64_ff == 6'h00) && (pre_ff == '0))
    else $error("divider reset did not clear the prescaler");
  AST_DIV_READ0: assert property (acc && !rsp_ff.pready && !apb_req.pwrite
    && addr_ok && addr == OFF_CTRL2 |=> apb_rsp.pready && !apb_rsp.prdata[1])
    else $error("divider reset bit read as one");
  AST_HALT_HOLD: assert property (!run_ff && !wr_en |=> $stable(tm_ff[IDX_SEC])
    && $stable(tm_ff[IDX_YEAR]))
    else $error("time moved while halted");
  AST_SEC_STEP: assert property (adv && tm_ff[IDX_SEC] < 8'h3B
    |=> tm_ff[IDX_SEC] == 8'($past(tm_ff[IDX_SEC]) + 8'h01))
    else $error("seconds did not advance");
  AST_TICK_FREE: assert property (!run_ff && tick64 && !div_rst && cnt64_ff != CNT64_MAX
    |=> cnt64_ff == 6'($past(cnt64_ff) + 6'h01))
    else $error("64 Hz count stalled with run low");
  AST_ALARM_SET: assert property (tick_d_ff && alarm_match |=> alarm_flag_ff)
    else $error("alarm match did not set the flag");
  AST_ALARM_CAUSE: assert property ($rose(alarm_flag_ff) |-> $past(tick_d_ff)
    && $past(alarm_match))
    else $error("alarm flag set without a match");
  AST_ALARM_FIELD: assert property (tick_d_ff && al_en[0]
    && alarm_ff[0][6:0] != tm_ff[0][6:0] |-> !alarm_match)
    else $error("enabled field mismatch ignored");
  AST_ALARM_IRQ: assert property (alarm_flag_ff && alarm_ie_ff |=> alarm_irq)
    else $error("alarm request missing");
  AST_WR_BLOCK: assert property (run_ff && wr_en && tm_hit[IDX_MIN] && !c_min
    |=> $stable(tm_ff[IDX_MIN]))
    else $error("time written while running");
  AST_PER_SET: assert property (per_fire |=> per_pulse)
    else $error("periodic flag and pulse sequence broken");
  AST_PER_CLEAR: assert property (per_flag_ff && !per_fire |=> !per_flag_ff)
    else $error("periodic flag not cleared");
  AST_MIN_ROLL: assert property (c_min |=> tm_ff[IDX_SEC] == 8'h00)
    else $error("seconds did not roll over");
endmodule

// File: testbench/rtc_core_tb_top.sv
// Self-checking testbench for the calendar clock core, driven over APB
`timescale 1ns/1ps
module rtc_core_tb_top;
  import rtc_pkg::*;
  // Short prescaler: one 64 Hz tick every 4 clocks, one second every 256
  localparam int unsigned DIV = 4;

  logic         clk;
  logic         rst_n;
  rtc_apb_req_t req;
  rtc_apb_rsp_t rsp;
  logic         alarm_irq;
  logic         periodic_irq;
  logic [31:0]  rng;
  logic [31:0]  q_dat[$];
  logic         q_err[$];
  int           err_count;
  int           n_checks;
  int           cyc = 0;
  int           t0;
  int           t1;
  int           t2;
  int           n;
  logic [7:0]   r8;

  rtc_core #(.PRESC_DIV_P(DIV)) rtc_core_i (
    .clk          (clk),
    .rst_n        (rst_n),
    .apb_req      (req),
    .apb_rsp      (rsp),
    .alarm_irq    (alarm_irq),
    .periodic_irq (periodic_irq)
  );

  // Clock, 10 ns period
  always #5 clk = ~clk;

  // Cycle stamp used to measure event spacing
  always @(posedge clk) cyc <= cyc + 1;

  task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic timeout(input string nm);
    err_count++;
    $display("FAIL %s expected event seen timeout", nm);
    report_and_stop();
  endtask

  // Watcher: each completed transfer is held against the oldest note
  always @(posedge clk) begin
    if (req.psel && req.penable && rsp.pready === 1'b1) begin
      if (q_dat.size() == 0) begin
        cmp("unexpected transfer", 32'h0, 32'h1);
      end else begin
        cmp($sformatf("prdata at %h", req.paddr), q_dat.pop_front(), rsp.prdata);
        cmp($sformatf("pslverr at %h", req.paddr), {31'h0, q_err.pop_front()}, {31'h0, rsp.pslverr});
      end
    end
  end

  // One APB transfer; an idle edge first so no signal is assigned twice in a step
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [31:0] ex, input logic er);
    int k;
    @(posedge clk);
    q_dat.push_back(ex);
    q_err.push_back(er);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= w;
    req.paddr   <= a;
    req.pwdata  <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 20);
    if (k >= 20) timeout("pready");
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, {24'h0, a}, {24'h0, d}, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] ex);
    apb(1'b0, {24'h0, a}, 32'h0, {24'h0, ex}, 1'b0);
  endtask

  function automatic logic [7:0] ta(input int i);
    return OFF_TIME + 8'(4 * i);
  endfunction

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // Waits for the next high cycle of an event output; always steps an edge first
  task automatic wait_hi(input logic use_alarm, output int t);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
      if (k > 2000) timeout("event output");
    end while ((use_alarm ? alarm_irq : periodic_irq) !== 1'b1);
    t = cyc;
  endtask

  // Halt, zero the seconds, then run again from a fresh divider
  task automatic restart;
    wr(OFF_CTRL2, 8'h08);
    wr(ta(IDX_SEC), 8'h00);
    wr(OFF_CTRL2, 8'h0B);
  endtask

  // Main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    req = '0;
    rng = 32'he25b8e26;
    err_count = 0;
    n_checks = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFF_CTRL2, 8'h09);
    rd(OFF_CTRL1, 8'h00);
    for (int i = 0; i < NUM_TIME; i++) rd(ta(i), TIME_FIRST[i]);
    apb(1'b0, 32'h100, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 32'h102, 32'h5A, 32'h0, 1'b1);
    // Counting is on, so a minute write must be dropped
    wr(ta(IDX_MIN), 8'(xs()) | 8'h01);
    rd(ta(IDX_MIN), 8'h00);
    $display("test reset and write lock done");

    wr(OFF_CTRL2, 8'h08);
    for (int i = 0; i < NUM_TIME; i++) wr(ta(i), TIME_MAX[i]);
    repeat (300) @(posedge clk);
    rd(ta(IDX_SEC), 8'h3B);
    wr(OFF_CTRL2, 8'h0B);
    rd(OFF_CTRL2, 8'h09);
    repeat (270) @(posedge clk);
    for (int i = 0; i < NUM_TIME; i++) rd(ta(i), TIME_FIRST[i]);
    // Seconds reread unchanged, so no carry fell inside the field reads
    rd(ta(IDX_SEC), TIME_FIRST[IDX_SEC]);
    wr(OFF_CTRL2, 8'h02);
    repeat (40) @(posedge clk);
    rd(OFF_CNT64, 8'h00);
    $display("test rollover and divider done");

    // Run stays off: events only come if the 64 Hz count keeps going
    for (int s = 1; s < 8; s++) begin
      wr(OFF_CTRL2, {1'b0, 3'(s), 4'hA});
      wait_hi(1'b0, t0);
      wait_hi(1'b0, t1);
      wait_hi(1'b0, t2);
      cmp($sformatf("periodic spacing sel %0d", s), 32'(DIV << (s - 1)), 32'(t2 - t1));
    end
    rd(OFF_CTRL2, 8'h78);
    wr(OFF_CTRL2, 8'h08);
    n = 0;
    repeat (600) begin
      @(posedge clk);
      if (periodic_irq !== 1'b0) n++;
    end
    cmp("periodic pulses when off", 32'h0, 32'(n));
    $display("test periodic done");

    r8 = 8'(2 + (xs() % 4));
    wr(OFF_ALARM, 8'h80 | r8);
    wr(OFF_ALARM + 8'h04, 8'h07);
    wr(OFF_ALARM + 8'h08, 8'h85);
    wr(OFF_CTRL1, 8'h08);
    restart();
    n = 0;
    repeat (1600) begin
      @(posedge clk);
      if (alarm_irq !== 1'b0) n++;
    end
    cmp("alarm with hour mismatch", 32'h0, 32'(n));
    rd(OFF_CTRL1, 8'h08);
    wr(OFF_ALARM + 8'h08, 8'h05);
    restart();
    wait_hi(1'b1, t0);
    rd(ta(IDX_SEC), r8);
    rd(OFF_CTRL1, 8'h09);
    wr(OFF_CTRL1, 8'h08);
    rd(OFF_CTRL1, 8'h08);
    repeat (3) @(posedge clk);
    cmp("alarm_irq after clear", 32'h0, {31'h0, alarm_irq});
    $display("test alarm done");
    report_and_stop();
  end
endmodule
